// File: core/bsg_gate.sv
// channel qualifier: prescaler, low-signal latch, continuous-signal latch
`timescale 1ns/100ps
`default_nettype none

module bsg_gate #(
  parameter int               LEVEL_W   = bsg_pkg::LEVEL_W,
  parameter logic [LEVEL_W-1:0] THRESHOLD = bsg_pkg::THRESHOLD_DEF
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // pins from the amplifier, gate generator and processor
  input  wire bsg_pkg::bsg_pins_t  pins,
  // detector sample, already on ref_clk
  input  wire logic [LEVEL_W-1:0]  det_level,
  // outputs to measurement logic and processor
  output bsg_pkg::bsg_stat_t       stat
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  bsg_pkg::bsg_pins_t sync1;
  bsg_pkg::bsg_pins_t sync2;
  logic               sig_prev;
  logic               gate_prev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // idle pin levels, so no false gate start follows reset
      sync1     <= '{sig: 1'b0, gate_n: 1'b1, sel: 1'b0};
      sync2     <= '{sig: 1'b0, gate_n: 1'b1, sel: 1'b0};
      sig_prev  <= 1'b0;
      gate_prev <= 1'b1;
    end else begin
      sync1     <= pins;
      sync2     <= sync1;
      sig_prev  <= sync2.sig;
      gate_prev <= sync2.gate_n;
    end
  end

  logic sig_rise;
  logic gate_open;
  logic gate_start;
  logic sel;

  assign sig_rise   = sync2.sig && !sig_prev;
  // gate line is active low; its inversion marks the open period
  assign gate_open  = !sync2.gate_n;
  assign gate_start = gate_prev && !sync2.gate_n;
  assign sel        = sync2.sel;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic pre_out;
  logic pre_edge;

  bsg_prescale #(
    .DIV_W (bsg_pkg::PRESCALE_W)
  ) u_pre (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .sig_rise (sig_rise),
    .pre_out  (pre_out),
    .pre_edge (pre_edge)
  );

  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  logic below;
  assign below = (det_level < THRESHOLD);

  // ----------------------------------------------------------------
  // latches and output stage
  // ----------------------------------------------------------------
  logic lowsig;
  logic cont_low;
  logic sig_out;
  logic a_inhibit;
  logic next_lowsig;
  logic next_cont_low;
  logic next_sig_out;
  logic next_a_inhibit;
  logic blocked;

  // force is combinational so a deselect closes the gate without waiting for an edge
  assign blocked = lowsig || !sel;

  always_comb begin
    next_lowsig    = lowsig;
    next_cont_low  = cont_low;
    if (!sel) begin
      next_lowsig = 1'b1;
    end else if (pre_edge) begin
      next_lowsig = !(!below);
    end
    if (gate_start) begin
      next_cont_low = 1'b0;
    end
    // set beats the clear when both land together
    if (gate_open && below) begin
      next_cont_low = 1'b1;
    end
    next_sig_out   = pre_out && !blocked;
    next_a_inhibit = sel;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowsig    <= bsg_pkg::LOWSIG_RST;
      cont_low  <= bsg_pkg::CONT_RST;
      sig_out   <= 1'b0;
      a_inhibit <= 1'b0;
    end else begin
      lowsig    <= next_lowsig;
      cont_low  <= next_cont_low;
      sig_out   <= next_sig_out;
      a_inhibit <= next_a_inhibit;
    end
  end

  assign stat.sig_out   = sig_out;
  assign stat.a_inhibit = a_inhibit;
  assign stat.cont_low  = cont_low;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_good_edge;
    sel && pre_edge && !below;
  endsequence

  sequence s_low_open;
    gate_open && below;
  endsequence

  sequence s_bad_edge;
    sel && pre_edge && below;
  endsequence

  sequence s_flag_start;
    gate_start && below;
  endsequence

  property p_cmp;
    @(posedge ref_clk) disable iff (srst) s_bad_edge |=> lowsig;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator sense wrong");

  property p_hold;
    @(posedge ref_clk) disable iff (srst) (sel && !pre_edge) |=> lowsig == $past(lowsig);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved without prescaler edge");

  property p_block;
    @(posedge ref_clk) disable iff (srst) blocked |=> !sig_out;
  endproperty
  a_block: assert property (p_block) else $error("gate open while blocked");

  property p_gate_close;
    @(posedge ref_clk) disable iff (srst) s_bad_edge ##1 1'b1 |=> !sig_out;
  endproperty
  a_gate_close: assert property (p_gate_close) else $error("gate still open after low edge");

  property p_pass;
    @(posedge ref_clk) disable iff (srst) sig_out |-> $past(pre_out) && !$past(blocked);
  endproperty
  a_pass: assert property (p_pass) else $error("output high without open gate and prescaler high");

  property p_reopen;
    @(posedge ref_clk) disable iff (srst) s_good_edge ##1 (sel && !pre_edge) |=> sig_out == $past(pre_out);
  endproperty
  a_reopen: assert property (p_reopen) else $error("gate did not reopen after good edge");

  property p_arm;
    @(posedge ref_clk) disable iff (srst) s_good_edge |=> !lowsig;
  endproperty
  a_arm: assert property (p_arm) else $error("latch not armed");

  property p_clear;
    @(posedge ref_clk) disable iff (srst) (gate_start && !below) |=> !cont_low;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared at gate start");

  property p_set;
    @(posedge ref_clk) disable iff (srst) s_low_open |=> cont_low [*1] ##0 (cont_low || gate_start);
  endproperty
  a_set: assert property (p_set) else $error("flag not set on low level in gate");

  property p_start_low;
    @(posedge ref_clk) disable iff (srst) s_flag_start |=> cont_low;
  endproperty
  a_start_low: assert property (p_start_low) else $error("clear beat set at gate start");

  property p_sticky;
    @(posedge ref_clk) disable iff (srst) (cont_low && !gate_start) |=> cont_low;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped outside gate start");

  property p_sel_buf;
    @(posedge ref_clk) disable iff (srst) 1'b1 |=> a_inhibit == $past(sel);
  endproperty
  a_sel_buf: assert property (p_sel_buf) else $error("inhibit does not follow select");

  property p_desel;
    @(posedge ref_clk) disable iff (srst) !sel |=> lowsig && !sig_out;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect did not force latch");

endmodule
`default_nettype wire

// File: shared/bsg_pkg.sv
// shared constants and carriers for the burst signal prescale gate
package bsg_pkg;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  localparam int          PRESCALE_DIV   = 64;
  localparam int          PRESCALE_W     = $clog2(PRESCALE_DIV);
  localparam logic [5:0]  PRESCALE_LAST  = 6'h3f;
  localparam logic [5:0]  PRESCALE_RST   = 6'h00;

  // ----------------------------------------------------------------
  // detector and reset values
  // ----------------------------------------------------------------
  localparam int          LEVEL_W        = 8;
  localparam logic [7:0]  THRESHOLD_DEF  = 8'h40;
  localparam logic        LOWSIG_RST     = 1'b1;
  localparam logic        CONT_RST       = 1'b0;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic sig;
    logic gate_n;
    logic sel;
  } bsg_pins_t;

  // status toward the measurement logic and processor
  typedef struct packed {
    logic sig_out;
    logic a_inhibit;
    logic cont_low;
  } bsg_stat_t;

endpackage

// File: core/bsg_prescale.sv
// divide-by-64 prescaler for the synchronised channel signal
`timescale 1ns/100ps
`default_nettype none

module bsg_prescale #(
  parameter int DIV_W = bsg_pkg::PRESCALE_W
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // signal
  input  wire logic             sig_rise,
  output logic                  pre_out,
  output logic                  pre_edge
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (sig_rise) begin
      next_cnt = cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= DIV_W'(bsg_pkg::PRESCALE_RST);
    end else begin
      cnt <= next_cnt;
    end
  end

  // msb gives a square wave at one sixty-fourth of the input rate
  assign pre_out  = cnt[DIV_W-1];
  assign pre_edge = sig_rise && (cnt == DIV_W'(bsg_pkg::PRESCALE_LAST));

  property p_div;
    @(posedge ref_clk) disable iff (srst)
      pre_edge |=> (cnt == DIV_W'(bsg_pkg::PRESCALE_RST)) && !pre_out;
  endproperty
  a_div: assert property (p_div) else $error("prescaler did not wrap after 64 edges");

endmodule
`default_nettype wire

// File: testbench/bsg_far_model.sv
// far-side model: measurement counter and processor flag sampling
`timescale 1ns/100ps
`default_nettype none

module bsg_far_model (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               srst,
  // channel status and gate line
  input  wire bsg_pkg::bsg_stat_t stat,
  input  wire logic               gate_n,
  // counted edges and result verdict
  output int                      edges,
  output logic                    result_zero
);
  logic last_out;
  logic last_gate_n;
  logic seen_low;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      edges       <= 0;
      last_out    <= 1'b0;
      last_gate_n <= 1'b1;
      seen_low    <= 1'b0;
      result_zero <= 1'b0;
    end else begin
      last_out    <= stat.sig_out;
      last_gate_n <= gate_n;
      if (stat.sig_out && !last_out) begin
        edges <= edges + 1;
      end
      // flag polled on every cycle the gate stands open
      if (!gate_n) begin
        seen_low <= seen_low | stat.cont_low;
      end
      // a period that saw the flag yields a zero result
      if (gate_n && !last_gate_n) begin
        result_zero <= seen_low | stat.cont_low;
        seen_low    <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/bsg_gate_test.sv
// self-checking bench for the channel qualifier
`timescale 1ns/100ps
`default_nettype none

module bsg_gate_test;
  logic               ref_clk;
  logic               srst;
  bsg_pkg::bsg_pins_t pins;
  logic [7:0]         det_level;
  bsg_pkg::bsg_stat_t stat;
  int                 edges;
  logic               result_zero;
  int                 n_fail;
  int                 checks_done;
  logic [31:0]        rs;
  logic               low;
  int                 e0;

  bsg_gate dut (.ref_clk(ref_clk), .srst(srst), .pins(pins), .det_level(det_level), .stat(stat));
  bsg_far_model far (.ref_clk(ref_clk), .srst(srst), .stat(stat), .gate_n(pins.gate_n),
    .edges(edges), .result_zero(result_zero));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // below-threshold values stay under the default threshold
  function automatic logic [7:0] lvl(input logic l, input logic [31:0] r);
    return l ? r[7:0] % 8'h40 : 8'h40 + r[7:0] % 8'hc0;
  endfunction

  function automatic int exp_rises(input int n);
    return n / bsg_pkg::PRESCALE_DIV;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // pulses kept two cycles high and low so the synchroniser sees each
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      rs = xs(rs);
      det_level = lvl(low, rs);
      pins.sig = 1'b1;
      cyc(2);
      pins.sig = 1'b0;
      @(negedge ref_clk);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t count got %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rs = 32'h00000063;
    low = 1'b0;
    srst = 1'b1;
    pins = '{sig: 1'b0, gate_n: 1'b1, sel: 1'b0};
    det_level = 8'h80;
    cyc(5);
    srst = 1'b0;
    pins.sel = 1'b1;
    pulse(128);
    chk_bit(stat.a_inhibit, 1'b1);
    e0 = edges;
    pulse(640);
    chk_cnt(edges - e0, exp_rises(640));
    low = 1'b1;
    pulse(128);
    e0 = edges;
    pulse(256);
    chk_cnt(edges - e0, 0);
    low = 1'b0;
    pulse(128);
    e0 = edges;
    pulse(640);
    chk_cnt(edges - e0, exp_rises(640));
    det_level = 8'h10;
    cyc(6);
    chk_bit(stat.cont_low, 1'b0);
    det_level = 8'h40;
    pins.gate_n = 1'b0;
    cyc(6);
    chk_bit(stat.cont_low, 1'b0);
    det_level = 8'h3f;
    cyc(1);
    det_level = 8'hff;
    cyc(15);
    chk_bit(stat.cont_low, 1'b1);
    pins.gate_n = 1'b1;
    cyc(4);
    chk_bit(result_zero, 1'b1);
    pins.gate_n = 1'b0;
    cyc(6);
    chk_bit(stat.cont_low, 1'b0);
    pins.gate_n = 1'b1;
    cyc(3);
    pins.gate_n = 1'b0;
    cyc(2);
    // level low only in the gate start cycle: set must win over the clear
    det_level = 8'h10;
    cyc(1);
    det_level = 8'h80;
    cyc(4);
    chk_bit(stat.cont_low, 1'b1);
    pins.sel = 1'b0;
    cyc(4);
    chk_bit(stat.a_inhibit, 1'b0);
    e0 = edges;
    pulse(256);
    chk_cnt(edges - e0, 0);
    complete_run();
  end
endmodule

`default_nettype wire
